/* File: tb/dpt_host_model.sv */
/*
 Host master model for the potentiometer serial core: drives chip select,
 serial clock and serial input, and collects the read byte from serial out.
 Assumes the caller leaves at least one frame gap between calls.
*/
`timescale 1ns/100ps
module dpt_host_model (
   // Link pins driven by the host
   output logic sck,
   output logic cs_n,
   output logic si,
   // Link pins driven by the device
   input wire logic so,
   input wire logic so_oe_n
);
   // Idle bus: chip select high so the first frame starts with a falling edge
   initial begin
      sck = 1'b0; // Clock stands still outside frames
      cs_n = 1'b1;
      si = 1'b0;
   end

   // One frame, n bits sent MSB first; bits 17..24 are captured from serial out
   task automatic frame(input logic [63:0] bits, input int n, output logic [7:0] rd);
      rd = 8'h00;
      #3.7; // Offset keeps the link edges off the system clock edges
      cs_n = 1'b0;
      #40;
      for (int i = 0; i < n; i++) begin
         si = bits[n - 1 - i];
         #40;
         sck = 1'b1;
         if (i >= 16 && i < 24) begin
            // An undriven output shows as unknown so a compare cannot pass
            rd = {rd[6:0], so_oe_n ? 1'bx : so};
         end
         #40;
         sck = 1'b0;
      end
      #80;
      cs_n = 1'b1;
      si = ~si; // Released line no longer shows the last bit
      #80;
   endtask
endmodule

/* File: tb/testbench.sv */
/*
 Self-checking bench of the potentiometer serial command core.
 Assumes the host model above and a shortened nonvolatile write time.
*/
`timescale 1ns/100ps
module testbench import dpt_pkg::*;;
   localparam logic [3:0] TYPE_ID = 4'h3; // Arbitrary type code
   localparam logic [23:0] STORE_SEED = 24'h71_C2A5;
   localparam logic [7:0] ID_BYTE = {TYPE_ID, ID_FIXED_BITS, 1'b1};
   logic CLK_SYS = 1'b0;
   logic RST = 1'b1;
   logic DEVSEL = 1'b1;
   logic WP_N = 1'b1;
   wire SCK, CS_N, SI, SO, SO_OE_N;
   logic [63:0] TAP_SEL;
   logic [5:0] WIPER_POS;
   logic NV_WRITE_BUSY;
   logic [7:0] rd;
   logic [15:0] bad_hdr [4];
   int miscompares = 0;
   int tests_run = 0;

   always #5 CLK_SYS = ~CLK_SYS;

   dpt_core #(.DEV_TYPE_ID(TYPE_ID), .NV_WRITE_CYCLES(50), .STORE_INIT(STORE_SEED)) dut (
      .CLK_SYS(CLK_SYS), .RST(RST), .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO),
      .SO_OE_N(SO_OE_N), .DEVSEL(DEVSEL), .WP_N(WP_N), .TAP_SEL(TAP_SEL),
      .WIPER_POS(WIPER_POS), .NV_WRITE_BUSY(NV_WRITE_BUSY));

   dpt_host_model host (.sck(SCK), .cs_n(CS_N), .si(SI), .so(SO), .so_oe_n(SO_OE_N));

   // Three-byte frame image with a valid header
   function automatic logic [23:0] cmd(input logic [7:0] ins, input logic [7:0] d);
      return {ID_BYTE, ins, d};
   endfunction

   // Frame, then enough system cycles for any load to land
   task automatic run(input logic [63:0] b, input int n);
      host.frame(b, n, rd);
      repeat (10) @(posedge CLK_SYS);
      #1;
   endtask

   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_pos(input logic [5:0] exp);
      tests_run++;
      if (WIPER_POS !== exp || TAP_SEL !== (64'h1 << exp)) begin
         miscompares++;
         $display("FAIL wiper expected %h seen %h taps %h", exp, WIPER_POS, TAP_SEL);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Bounded wait for the nonvolatile write to finish
   task automatic wait_idle();
      for (int i = 0; i < 200 && NV_WRITE_BUSY !== 1'b0; i++) begin
         @(posedge CLK_SYS);
         #1;
      end
      if (NV_WRITE_BUSY !== 1'b0) begin
         miscompares++;
         $display("FAIL busy wait expected 0 seen %b", NV_WRITE_BUSY);
         complete_run();
      end
   endtask

   // Main sequence; each test ends with one line
   initial begin
      bad_hdr[0] = {TYPE_ID, ID_FIXED_BITS, 1'b0, OP_WIPER_WR, 4'h0};
      bad_hdr[1] = {~TYPE_ID, ID_FIXED_BITS, 1'b1, OP_WIPER_WR, 4'h0};
      bad_hdr[2] = {TYPE_ID, 3'h5, 1'b1, OP_WIPER_WR, 4'h0};
      bad_hdr[3] = {ID_BYTE, OP_WIPER_WR, 4'h1};
      repeat (5) @(posedge CLK_SYS);
      #1 RST = 1'b0;
      repeat (5) @(posedge CLK_SYS);
      #1;
      chk_pos(6'h25);
      chk_byte("busy", 8'h00, {7'h0, NV_WRITE_BUSY});
      $display("test power_up done");
      run(cmd({OP_WIPER_WR, 4'h0}, 8'hFE), 24);
      chk_pos(6'h3E);
      run(cmd({OP_WIPER_RD, 4'h0}, 8'h00), 24);
      chk_byte("wiper read", 8'h3E, rd);
      $display("test wiper_rw done");
      run({ID_BYTE, OP_INCDEC, 4'h0, 2'b11}, 18);
      chk_pos(6'h3F);
      run({ID_BYTE, OP_INCDEC, 4'h0, 3'b000}, 19);
      chk_pos(6'h3C);
      run(cmd({OP_WIPER_WR, 4'h0}, 8'h01), 24);
      run({ID_BYTE, OP_INCDEC, 4'h0, 3'b001}, 19);
      chk_pos(6'h01);
      $display("test step done");
      run(cmd({OP_STORE_WR, 2'h2, 2'h0}, 8'hD5), 24);
      chk_byte("busy", 8'h01, {7'h0, NV_WRITE_BUSY});
      run(cmd({OP_STATUS, STATUS_LOW_NIB}, 8'h00), 24);
      chk_byte("status", 8'h01, rd);
      wait_idle();
      run(cmd({OP_STATUS, STATUS_LOW_NIB}, 8'h00), 24);
      chk_byte("status", 8'h00, rd);
      run(cmd({OP_STORE_RD, 2'h2, 2'h0}, 8'h00), 24);
      chk_byte("stored 2", 8'h15, rd);
      $display("test stored_write done");
      run(cmd({OP_STORE_WR, 2'h1, 2'h0}, 8'hFF) >> 4, 20);
      chk_byte("busy", 8'h00, {7'h0, NV_WRITE_BUSY});
      WP_N = 1'b0;
      run(cmd({OP_STORE_WR, 2'h1, 2'h0}, 8'hFF), 24);
      chk_byte("busy", 8'h00, {7'h0, NV_WRITE_BUSY});
      run(cmd({OP_WIPER_WR, 4'h0}, 8'h11), 24);
      chk_pos(6'h11);
      WP_N = 1'b1;
      run(cmd({OP_STORE_RD, 2'h1, 2'h0}, 8'h00), 24);
      chk_byte("stored 1", 8'h0A, rd);
      $display("test protect done");
      run(cmd({OP_LOAD_WIPER, 2'h2, 2'h0}, 8'h00) >> 8, 16);
      chk_pos(6'h15);
      run(cmd({OP_SAVE_WIPER, 2'h3, 2'h0}, 8'h00) >> 8, 16);
      chk_byte("busy", 8'h01, {7'h0, NV_WRITE_BUSY});
      wait_idle();
      run(cmd({OP_STORE_RD, 2'h3, 2'h0}, 8'h00), 24);
      chk_byte("stored 3", 8'h15, rd);
      $display("test transfer done");
      // Every bad header must leave the wiper where it was
      for (int k = 0; k < 4; k++) begin
         run({bad_hdr[k], 8'h2A}, 24);
         chk_pos(6'h15);
      end
      $display("test refused done");
      complete_run();
   end
endmodule

/* File: verilog/dpt_core.sv */
/*
 Top of the potentiometer serial command core: wiper register, four stored
 settings, nonvolatile write timing and one-hot tap decode, on CLK_SYS.
 Assumes SCK runs only inside frames and that CS_N, WP_N and DEVSEL are
 asynchronous pins. The analog array sits outside and reads TAP_SEL.
*/
`timescale 1ns/100ps

// How it works
// - Six-bit wiper value is decoded to select one of sixty-four taps.
// - Tap select output is always strictly one-hot.
// - Wiper changes only by write, transfer, step or power-up load.
// - After reset the wiper loads from stored setting zero.
// - Four six-bit stored settings; each change is a timed nonvolatile write.
// - Wiper and stored values read as bytes with upper two bits zero.
// - Nonvolatile save starts only at chip select rise after complete sequence.
// - Busy flag shows a running write and is returned by status read.
// - First byte is identification; upper four bits match device type.
// - Identification LSB must match the device select pin to continue.
// - Instruction byte holds opcode, two-bit pointer, then two zero bits.
// - Eight opcodes decode as listed; status needs low nibble 0001.
// - Both transfers end after the instruction byte with no data.
// - Stored-to-wiper transfer is an immediate volatile load.
// - Wiper-to-stored transfer is a full nonvolatile write.
// - Read, write and status commands carry a third data byte.
// - Increment step per serial clock pulse with serial input high.
// - Decrement step per serial clock pulse with serial input low.
// - Write protect low blocks stored writes but not wiper writes.
// - Bus is ignored until chip select falls after reset.
// - Input taken on rising serial clock, output shifted on falling.
// - Wiper output settles within ten microseconds of a load.
module dpt_core import dpt_pkg::*; #(
   parameter logic [3:0] DEV_TYPE_ID = 4'hA, // Arbitrary type code
   parameter int NV_WRITE_CYCLES = NV_WRITE_CYC,
   parameter logic [23:0] STORE_INIT = STORE_RESET
) (
   // System clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // Serial host link
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic SI,
   output logic SO,
   output logic SO_OE_N,
   // Straps
   input wire logic DEVSEL,
   input wire logic WP_N,
   // Potentiometer side
   output logic [63:0] TAP_SEL,
   output logic [5:0] WIPER_POS,
   output logic NV_WRITE_BUSY
);

   localparam logic [NV_CNT_W-1:0] NV_LAST = NV_CNT_W'(NV_WRITE_CYCLES - 1);
   localparam int SettleMax = WIPER_SETTLE_CYC;

   // The countdown must fit its counter and last at least one cycle
   if (NV_WRITE_CYCLES < 1 || NV_WRITE_CYCLES >= (1 << NV_CNT_W)) begin : g_bad_nv
      $error("NV_WRITE_CYCLES out of range");
   end

   typedef struct packed {
      dpt_sy_state_t state;
      logic [5:0] wiper;
      logic [3:0][5:0] store;
      logic busy;
      logic [NV_CNT_W-1:0] nv_cnt;
      dpt_pend_t pend;
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic wp_s1;
      logic wp_s2;
      logic tg_s1;
      logic tg_s2;
      logic tg_s3;
      logic armed;
      logic frame_ok;
      dpt_snap_t snap;
      logic [63:0] tap;
   } dpt_sy_t;

   dpt_sy_t sy_reg, sy_next;
   dpt_cmd_t link_cmd;
   logic link_tgl;
   logic link_rst;
   logic cs_rise;
   logic cs_fall;
   logic accept;
   logic init_st;
   logic [63:0] tap_dec;

   // Link frame state is held in reset whenever the host deselects the core
   assign link_rst = RST | CS_N;

   dpt_link #(
      .DEV_TYPE_ID(DEV_TYPE_ID)
   ) u_link (
      .sck(SCK),
      .rst(RST),
      .frame_rst(link_rst),
      .si(SI),
      .so(SO),
      .so_oe_n(SO_OE_N),
      .dev_sel(DEVSEL),
      .snap(sy_reg.snap),
      .cmd(link_cmd),
      .cmd_tgl(link_tgl)
   );

   // One comparator per tap
   for (genvar i = 0; i < TAP_COUNT; i++) begin : g_tap
      assign tap_dec[i] = (sy_reg.wiper == 6'(i));
   end

   // Pin edges, seen only through the second synchroniser stage
   assign cs_rise = sy_reg.cs_s2 & ~sy_reg.cs_s3;
   assign cs_fall = ~sy_reg.cs_s2 & sy_reg.cs_s3;
   assign init_st = (sy_reg.state == SY_INIT);
   // Link events count only inside a frame opened after reset
   assign accept = (sy_reg.tg_s2 ^ sy_reg.tg_s3) & sy_reg.frame_ok & ~init_st;

   // Next-state logic of the system domain
   always_comb begin
      sy_next = sy_reg;
      sy_next.cs_s1 = CS_N;
      sy_next.cs_s2 = sy_reg.cs_s1;
      sy_next.cs_s3 = sy_reg.cs_s2;
      sy_next.wp_s1 = WP_N;
      sy_next.wp_s2 = sy_reg.wp_s1;
      sy_next.tg_s1 = link_tgl;
      sy_next.tg_s2 = sy_reg.tg_s1;
      sy_next.tg_s3 = sy_reg.tg_s2;
      sy_next.tap = tap_dec;

      // A frame is trusted only if chip select was seen high first
      if (sy_reg.cs_s2) begin
         sy_next.armed = 1'b1;
      end
      if (cs_fall) begin
         sy_next.frame_ok = sy_reg.armed;
      end

      // Write timer: busy stays up for the full write time
      if (sy_reg.busy) begin
         if (sy_reg.nv_cnt == '0) begin
            sy_next.busy = 1'b0;
         end else begin
            sy_next.nv_cnt = sy_reg.nv_cnt - NV_CNT_W'(1);
         end
      end

      case (sy_reg.state)
         SY_INIT: begin
            // Power-up recall of stored setting zero
            sy_next.wiper = sy_reg.store[0];
            sy_next.state = SY_RUN;
         end
         SY_RUN: begin
            if (accept) begin
               case (link_cmd.kind)
                  EV_STEP: begin
                     // Saturating single steps
                     if (link_cmd.up && sy_reg.wiper != WIPER_MAX) begin
                        sy_next.wiper = sy_reg.wiper + 6'h01;
                     end else if (!link_cmd.up && sy_reg.wiper != WIPER_MIN) begin
                        sy_next.wiper = sy_reg.wiper - 6'h01;
                     end
                  end
                  EV_CMD: begin
                     case (link_cmd.op)
                        OP_WIPER_WR: begin
                           // Wiper writes ignore write protect
                           sy_next.wiper = link_cmd.data;
                        end
                        OP_LOAD_WIPER: begin
                           sy_next.wiper = sy_reg.store[link_cmd.ptr];
                        end
                        OP_STORE_WR: begin
                           sy_next.pend = '{1'b1, link_cmd.ptr, link_cmd.data};
                        end
                        OP_SAVE_WIPER: begin
                           sy_next.pend = '{1'b1, link_cmd.ptr, sy_reg.wiper};
                        end
                        default: begin
                           sy_next.pend = sy_reg.pend;
                        end
                     endcase
                  end
                  default: begin
                     sy_next.pend = sy_reg.pend;
                  end
               endcase
            end
         end
         default: begin
            sy_next.state = SY_INIT;
         end
      endcase

      // Save starts only on deselect after a finished write sequence
      if (cs_rise) begin
         // Protect pin and a running write both refuse the save
         if (sy_next.pend.valid && sy_reg.wp_s2 && !sy_reg.busy) begin
            sy_next.store[sy_next.pend.ptr] = sy_next.pend.val;
            sy_next.busy = 1'b1;
            sy_next.nv_cnt = NV_LAST;
         end
         sy_next.pend.valid = 1'b0;
      end

      // Read-back view is frozen while a frame runs, so the link reads it safely
      if (sy_reg.cs_s2) begin
         sy_next.snap = '{sy_reg.busy, sy_reg.wiper, sy_reg.store};
      end
   end

   // State register
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         sy_reg <= '{
            state: SY_INIT,
            wiper: WIPER_MIN,
            store: STORE_INIT,
            busy: 1'b0,
            nv_cnt: '0,
            pend: '0,
            // Chip select stages start low so only a real high arms the first frame;
            // the rise this shows after reset finds no pending save and does nothing
            cs_s1: 1'b0,
            cs_s2: 1'b0,
            cs_s3: 1'b0,
            wp_s1: 1'b0,
            wp_s2: 1'b0,
            tg_s1: 1'b0,
            tg_s2: 1'b0,
            tg_s3: 1'b0,
            armed: 1'b0,
            frame_ok: 1'b0,
            snap: '0,
            tap: TAP_RESET
         };
      end else begin
         sy_reg <= sy_next;
      end
   end

   // Outputs straight from flip-flops
   assign TAP_SEL = sy_reg.tap;
   assign WIPER_POS = sy_reg.wiper;
   assign NV_WRITE_BUSY = sy_reg.busy;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   // Never two switches closed at once
   tap_onehot_a: assert property ($onehot(sy_reg.tap))
      else $error("tap select not one-hot");

   // Tap select follows the wiper one cycle later
   tap_decode_a: assert property (1'b1 |=> sy_reg.tap[$past(sy_reg.wiper)])
      else $error("tap select does not match wiper");

   // Recall of stored setting zero on leaving reset
   powerup_load_a: assert property (init_st |=>
      (sy_reg.wiper == $past(sy_reg.store[0])) && (sy_reg.state == SY_RUN))
      else $error("power-up recall missing");

   // Wiper moves only for an accepted event or the recall
   wiper_source_a: assert property ($changed(sy_reg.wiper) |->
      $past(accept) || $past(init_st))
      else $error("wiper changed without cause");

   // Busy starts with the full countdown loaded
   nv_start_a: assert property ($rose(sy_reg.busy) |-> sy_reg.nv_cnt == NV_LAST)
      else $error("write time wrong");

   // Countdown steps by one each cycle, so busy lasts exactly the write time
   nv_count_a: assert property (sy_reg.busy && sy_reg.nv_cnt != '0 |=>
      sy_reg.busy && (sy_reg.nv_cnt == $past(sy_reg.nv_cnt) - NV_CNT_W'(1)))
      else $error("write countdown skipped");

   // Busy ends only when the countdown is spent
   nv_end_a: assert property ($fell(sy_reg.busy) |-> $past(sy_reg.nv_cnt) == '0)
      else $error("write ended early");

   // A save starts only on chip select rise
   nv_on_cs_a: assert property ($rose(sy_reg.busy) |-> $past(cs_rise))
      else $error("save started without deselect");

   // Write protect low blocks every save
   wp_block_a: assert property ($rose(sy_reg.busy) |-> $past(sy_reg.wp_s2))
      else $error("save while write protected");

   // Step up adds exactly one below the top
   step_up_a: assert property (accept && link_cmd.kind == EV_STEP && link_cmd.up &&
      sy_reg.wiper != WIPER_MAX |=> sy_reg.wiper == $past(sy_reg.wiper) + 6'h01)
      else $error("step up wrong");

   // Step down removes exactly one above the bottom
   step_down_a: assert property (accept && link_cmd.kind == EV_STEP && !link_cmd.up &&
      sy_reg.wiper != WIPER_MIN |=> sy_reg.wiper == $past(sy_reg.wiper) - 6'h01)
      else $error("step down wrong");

   // Steps hold at either end
   step_clamp_a: assert property (accept && link_cmd.kind == EV_STEP &&
      ((link_cmd.up && sy_reg.wiper == WIPER_MAX) ||
       (!link_cmd.up && sy_reg.wiper == WIPER_MIN)) |=> $stable(sy_reg.wiper))
      else $error("step passed array end");

   // Tap output settles well inside the response limit
   settle_time_a: assert property ($changed(sy_reg.wiper) |->
      ##[1:SettleMax] sy_reg.tap[sy_reg.wiper])
      else $error("wiper output did not settle");

   // Write protect does not hold back a wiper write
   wiper_write_a: assert property (accept && link_cmd.kind == EV_CMD &&
      link_cmd.op == OP_WIPER_WR |=> sy_reg.wiper == $past(link_cmd.data))
      else $error("wiper write lost");

   // Stored settings cannot change while a write is still timing out
   store_hold_a: assert property (sy_reg.busy |=> $stable(sy_reg.store))
      else $error("stored setting changed during write");

   // A save writes the pending value into the pointed setting
   save_store_a: assert property ($rose(sy_reg.busy) |->
      sy_reg.store[$past(sy_reg.pend.ptr)] == $past(sy_reg.pend.val))
      else $error("saved value wrong");

   // A deselect always drops a pending save, taken or refused
   pend_drop_a: assert property (cs_rise |=> !sy_reg.pend.valid)
      else $error("pending save survived deselect");

   // Read-back view stays frozen while a frame runs
   snap_frozen_a: assert property (!sy_reg.cs_s2 |=> $stable(sy_reg.snap))
      else $error("read-back view changed in frame");

   // Only a fall after a seen high opens a trusted frame
   frame_gate_a: assert property ($rose(sy_reg.frame_ok) |->
      $past(cs_fall) && $past(sy_reg.armed))
      else $error("frame trusted without chip select edge");

endmodule

/* File: verilog/dpt_link.sv */
/*
 Serial link front end, clocked by the host's serial clock.
 Assumes frame_rst is high whenever chip select is high, and that the
 snapshot input stays stable while a frame is in progress.
*/
`timescale 1ns/100ps
module dpt_link import dpt_pkg::*; #(
   parameter logic [3:0] DEV_TYPE_ID = 4'hA
) (
   // Link clock and resets
   input wire logic sck,
   input wire logic rst,
   input wire logic frame_rst,
   // Serial data
   input wire logic si,
   output logic so,
   output logic so_oe_n,
   // Device select strap
   input wire logic dev_sel,
   // Register view from the system domain
   input dpt_snap_t snap,
   // Command event, held word plus toggle
   output dpt_cmd_t cmd,
   output logic cmd_tgl
);

   typedef struct packed {
      dpt_lk_state_t state;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [3:0] op;
      logic [1:0] ptr;
      logic sel_s1;
      logic sel_s2;
   } dpt_lk_t;

   dpt_lk_t lk_reg, lk_next;
   dpt_cmd_t cmd_reg, cmd_next;
   logic tgl_reg, tgl_next;
   logic so_reg;
   logic [7:0] byte_in;
   logic done;
   logic emit;

   // Frame decoder: bits are taken on the rising edge
   always_comb begin
      byte_in = {lk_reg.sh[6:0], si};
      done = (lk_reg.cnt == 3'h7);
      lk_next = lk_reg;
      cmd_next = cmd_reg;
      emit = 1'b0;
      lk_next.cnt = lk_reg.cnt + 3'h1;
      lk_next.sh = byte_in;
      lk_next.sel_s1 = dev_sel;
      lk_next.sel_s2 = lk_reg.sel_s1;
      case (lk_reg.state)
         LK_ID: begin
            // Type field, fixed bits and select pin must all match
            if (done) begin
               if (byte_in[7:4] == DEV_TYPE_ID && byte_in[3:1] == ID_FIXED_BITS &&
                   byte_in[0] == lk_reg.sel_s2) begin
                  lk_next.state = LK_INSTR;
               end else begin
                  lk_next.state = LK_IDLE;
               end
            end
         end
         LK_INSTR: begin
            if (done) begin
               lk_next.op = byte_in[7:4];
               lk_next.ptr = byte_in[3:2];
               lk_next.state = LK_IDLE;
               if (byte_in[1:0] == INSTR_LOW_ZERO) begin
                  case (byte_in[7:4])
                     OP_WIPER_RD: begin
                        lk_next.tx = {2'h0, snap.wiper};
                        lk_next.state = LK_RDATA;
                     end
                     OP_STORE_RD: begin
                        lk_next.tx = {2'h0, snap.store[byte_in[3:2]]};
                        lk_next.state = LK_RDATA;
                     end
                     OP_WIPER_WR, OP_STORE_WR: begin
                        lk_next.state = LK_WDATA;
                     end
                     OP_LOAD_WIPER, OP_SAVE_WIPER: begin
                        // Complete after two bytes
                        emit = 1'b1;
                        cmd_next.kind = EV_CMD;
                        cmd_next.op = byte_in[7:4];
                        cmd_next.ptr = byte_in[3:2];
                     end
                     OP_INCDEC: begin
                        lk_next.state = LK_STEP;
                     end
                     default: begin
                        lk_next.state = LK_IDLE;
                     end
                  endcase
               end else if (byte_in == {OP_STATUS, STATUS_LOW_NIB}) begin
                  lk_next.tx = {7'h00, snap.busy};
                  lk_next.state = LK_RDATA;
               end
            end
         end
         LK_WDATA: begin
            if (done) begin
               emit = 1'b1;
               cmd_next.kind = EV_CMD;
               cmd_next.op = lk_reg.op;
               cmd_next.ptr = lk_reg.ptr;
               cmd_next.data = byte_in[5:0];
               lk_next.state = LK_IDLE;
            end
         end
         LK_RDATA: begin
            if (done) begin
               lk_next.state = LK_IDLE;
            end
         end
         LK_STEP: begin
            // One step per rising edge, direction from serial input
            emit = 1'b1;
            cmd_next.kind = EV_STEP;
            cmd_next.up = si;
         end
         default: begin
            lk_next.state = LK_IDLE;
         end
      endcase
      tgl_next = tgl_reg ^ emit;
   end

   // Frame state restarts with every chip select
   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         lk_reg <= '{LK_ID, 3'h0, 8'h00, 8'h00, 4'h0, 2'h0, 1'b0, 1'b0};
      end else begin
         lk_reg <= lk_next;
      end
   end

   // Event toggle survives chip select so the far side never sees a false edge
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         cmd_reg <= '{EV_NONE, 4'h0, 2'h0, 6'h00, 1'b0};
         tgl_reg <= 1'b0;
      end else begin
         cmd_reg <= cmd_next;
         tgl_reg <= tgl_next;
      end
   end

   // Read data leaves on the falling edge, MSB first
   always_ff @(negedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         so_reg <= 1'b0;
      end else begin
         so_reg <= lk_reg.tx[3'h7 - lk_reg.cnt];
      end
   end

   assign so = so_reg;
   assign so_oe_n = (lk_reg.state != LK_RDATA);
   assign cmd = cmd_reg;
   assign cmd_tgl = tgl_reg;

endmodule

/* File: verilog/dpt_pkg.sv */
/*
 Shared constants and types of the digital potentiometer serial command core.
 Assumes a 100 MHz system clock and a serial clock that runs only within frames.
*/
package dpt_pkg;

   // Identification byte: fixed pattern between the type field and select bit
   localparam logic [2:0] ID_FIXED_BITS = 3'h6;

   // Instruction opcodes (upper nibble of the instruction byte)
   localparam logic [3:0] OP_WIPER_RD = 4'h9;
   localparam logic [3:0] OP_WIPER_WR = 4'hA;
   localparam logic [3:0] OP_STORE_RD = 4'hB;
   localparam logic [3:0] OP_STORE_WR = 4'hC;
   localparam logic [3:0] OP_LOAD_WIPER = 4'hD;
   localparam logic [3:0] OP_SAVE_WIPER = 4'hE;
   localparam logic [3:0] OP_INCDEC = 4'h2;
   localparam logic [3:0] OP_STATUS = 4'h5;
   localparam logic [3:0] STATUS_LOW_NIB = 4'h1;
   localparam logic [1:0] INSTR_LOW_ZERO = 2'h0;

   // Array geometry
   localparam int TAP_COUNT = 64;
   localparam logic [5:0] WIPER_MAX = 6'h3F;
   localparam logic [5:0] WIPER_MIN = 6'h00;
   localparam logic [63:0] TAP_RESET = 64'h0000_0000_0000_0001;
   localparam logic [23:0] STORE_RESET = 24'h00_0000;

   // Timing, in printed units, and derived cycle counts
   localparam int SYS_CLK_MHZ = 100;
   localparam int NV_WRITE_MS = 10;
   localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000 * SYS_CLK_MHZ;
   localparam int WIPER_SETTLE_US = 10;
   localparam int WIPER_SETTLE_CYC = WIPER_SETTLE_US * SYS_CLK_MHZ;
   localparam int NV_CNT_W = 20;

   // Events that the link hands to the system domain
   typedef enum logic [1:0] {EV_NONE = 2'b00, EV_CMD = 2'b01, EV_STEP = 2'b10} dpt_evt_t;

   typedef struct packed {
      dpt_evt_t kind;
      logic [3:0] op;
      logic [1:0] ptr;
      logic [5:0] data;
      logic up;
   } dpt_cmd_t;

   // Register view that the link reads back
   typedef struct packed {
      logic busy;
      logic [5:0] wiper;
      logic [3:0][5:0] store;
   } dpt_snap_t;

   typedef struct packed {
      logic valid;
      logic [1:0] ptr;
      logic [5:0] val;
   } dpt_pend_t;

   typedef enum logic [2:0] {
      LK_ID = 3'b000, LK_INSTR = 3'b001, LK_WDATA = 3'b010,
      LK_RDATA = 3'b011, LK_STEP = 3'b100, LK_IDLE = 3'b101
   } dpt_lk_state_t;

   typedef enum logic {SY_INIT = 1'b0, SY_RUN = 1'b1} dpt_sy_state_t;

endpackage
